// >>> core/ecpm_pkg.sv
// shared constants and types for the point multiply / verify engine
package ecpm_pkg;

   // field and bus geometry, fixed per build
   localparam int M    = 163;                // field degree
   localparam int W    = 32;                 // memory word width
   localparam int NW   = (M + W - 1) / W;    // words per field element
   localparam int PADW = NW * W;             // padded element width
   localparam int AW   = 8;                  // memory address width
   localparam int WXW  = 5;                  // transfer word index width

   // reduction polynomial low terms and curve coefficients
   localparam logic [M-1:0] POLY    = 163'hC9;
   localparam logic [M-1:0] CURVE_A = 163'h1;
   localparam logic [M-1:0] CURVE_B = 163'h1;

   // memory map, word addresses
   localparam logic [AW-1:0] K_BASE   = AW'(0);
   localparam logic [AW-1:0] RES_BASE = AW'(3 * NW);

   // transfer index marks
   localparam logic [WXW-1:0] WX_K_LAST  = WXW'(NW - 1);
   localparam logic [WXW-1:0] WX_X_LAST  = WXW'(2 * NW - 1);
   localparam logic [WXW-1:0] WX_Y_LAST  = WXW'(3 * NW - 1);
   localparam logic [WXW-1:0] WX_QY      = WXW'(NW);
   localparam logic [WXW-1:0] WX_STAT    = WXW'(2 * NW);
   localparam logic [WXW-1:0] WX_ZERO    = WXW'(0);

   // status word bits
   localparam int STAT_PASS_BIT = 0;
   localparam int STAT_INF_BIT  = 1;
   localparam int STAT_MODE_BIT = 2;

   // register file indices
   localparam logic [3:0] R_X   = 4'h0;
   localparam logic [3:0] R_Y   = 4'h1;
   localparam logic [3:0] R_X1  = 4'h2;
   localparam logic [3:0] R_Z1  = 4'h3;
   localparam logic [3:0] R_X2  = 4'h4;
   localparam logic [3:0] R_Z2  = 4'h5;
   localparam logic [3:0] R_T   = 4'h6;
   localparam logic [3:0] R_U   = 4'h7;
   localparam logic [3:0] R_V   = 4'h8;
   localparam logic [3:0] R_WW  = 4'h9;
   localparam logic [3:0] R_B   = 4'hA;
   localparam logic [3:0] R_ONE = 4'hB;
   localparam logic [3:0] R_A   = 4'hC;
   localparam int         RF_N  = 10;
   localparam logic [3:0] SWAP_XOR = 4'h6;

   // microprogram entry points and counts
   localparam logic [5:0] PC_LADDER  = 6'h00;
   localparam logic [5:0] PC_LAST_LD = 6'h0E;
   localparam logic [5:0] PC_POST    = 6'h0F;
   localparam logic [5:0] PC_END_MUL = 6'h26;
   localparam logic [5:0] PC_VERIFY  = 6'h27;
   localparam logic [5:0] LOOP_BACK  = 6'h02;
   localparam logic [7:0] INV_LOOPS  = 8'(M - 2);
   localparam logic [7:0] BIT_TOP    = 8'(M - 1);

   typedef enum logic [2:0] {
      OP_MUL  = 3'b000,
      OP_ADD  = 3'b001,
      OP_LOOP = 3'b010,
      OP_STEP = 3'b011,
      OP_END  = 3'b100
   } uop_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_LOAD  = 3'b001,
      S_EXEC  = 3'b010,
      S_MULW  = 3'b011,
      S_STORE = 3'b100,
      S_DONE  = 3'b101
   } state_t;

endpackage

// >>> core/gf_mul.sv
// bit-serial multiplier over the binary field, one bit per cycle
`timescale 1ns/10ps
module gf_mul
   import ecpm_pkg::*;
(
   // clock, reset, enable
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // operands and start
   input  wire logic         start,
   input  wire logic [M-1:0] a,
   input  wire logic [M-1:0] b,
   // product
   output logic [M-1:0]      p,
   output logic              done
);

   logic [M-1:0] a_q;        // latched multiplicand
   logic [M-1:0] b_q;        // latched multiplier
   logic [M-1:0] acc_q;      // running product
   logic [7:0]   cnt_q;      // multiplier bit index
   logic         busy_q;     // product in progress
   logic         done_q;     // one-cycle completion
   logic [M-1:0] acc_sh;     // acc times x, reduced
   logic [M-1:0] acc_d;      // next product

   // msb-first: shift, fold the top bit back, add a if bit set
   assign acc_sh = {acc_q[M-2:0], 1'b0} ^ (acc_q[M-1] ? POLY : '0);
   assign acc_d  = acc_sh ^ (b_q[cnt_q] ? a_q : '0);
   assign p      = acc_q;
   assign done   = done_q;

   ////////////////////////////////////////////////////////////////////////
   // sequencing; a start while busy is ignored
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         a_q    <= '0;
         b_q    <= '0;
         acc_q  <= '0;
         cnt_q  <= 8'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else if (ce) begin
         done_q <= 1'b0;
         if (start && !busy_q) begin
            a_q    <= a;
            b_q    <= b;
            acc_q  <= '0;
            cnt_q  <= BIT_TOP;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            acc_q <= acc_d;
            if (cnt_q == 8'h00) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end
      end
   end

endmodule // gf_mul

// >>> core/ec_point_engine.sv
// point multiply / point verify engine over shared memory
// Operation
// - mode low multiplies, mode high verifies
// - a rising start edge begins the selected operation
// - reset high clears control asynchronously, not field registers
// - done output high marks computation finished
// - read request fetches operands from memory
// - write request stores results to memory
// - results written back to shared memory
// - field degree, curve, word width fixed
// - multiply computes Q equal k times P
// - verify checks point satisfies curve equation
// - Koblitz curve form only, a and b both fixed at one
// - degree chosen per build, one fixed curve
// - memory touched in few cycles only
`timescale 1ns/10ps
module ec_point_engine
   import ecpm_pkg::*;
(
   // clock, reset, enable
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          ce,
   // host control
   input  wire logic          start,
   input  wire logic          mode,
   output logic               done,
   // shared memory port
   output logic               mem_rd_req,
   output logic               mem_wr_req,
   output logic [AW-1:0]      mem_addr,
   output logic [W-1:0]       mem_wr_data,
   input  wire logic [W-1:0]  mem_rd_data,
   input  wire logic          mem_ack
);

   state_t         state_q;      // main sequencer
   logic           start_q;      // start seen last cycle
   logic           mode_q;       // operation latched at start
   logic           done_q;       // completion flag
   logic           rd_req_q;     // read request
   logic           wr_req_q;     // write request
   logic [AW-1:0]  addr_q;       // request address
   logic [W-1:0]   wdata_q;      // write data
   logic [WXW-1:0] widx_q;       // word index of transfer
   logic [PADW-1:0] in_buf_q;    // assembles incoming element
   logic [PADW-1:0] out_buf_q;   // drains outgoing element
   logic [M-1:0]   k_q;          // scalar, msb shifted out first
   logic [7:0]     bits_q;       // ladder bits left
   logic [7:0]     loop_q;       // inversion iterations left
   logic [5:0]     pc_q;         // microprogram counter
   logic           inf_q;        // result is the point at infinity
   logic [M-1:0]   rf_q [0:RF_N-1]; // working field registers

   ////////////////////////////////////////////////////////////////////////
   // micro-ops by address; slot 26 and all codes past 2F end the program
   localparam logic [14:0] UEND = {OP_END, R_X, R_X, R_X};
   localparam logic [14:0] UCODE [0:47] = '{
      {OP_MUL,R_U,R_X1,R_Z2},{OP_MUL,R_Z1,R_Z1,R_X2},{OP_MUL,R_V,R_U,R_Z1},
      {OP_ADD,R_Z1,R_Z1,R_U},{OP_MUL,R_Z1,R_Z1,R_Z1},{OP_MUL,R_U,R_X,R_Z1},
      {OP_ADD,R_X1,R_U,R_V},{OP_MUL,R_U,R_X2,R_X2},{OP_MUL,R_V,R_Z2,R_Z2},
      {OP_MUL,R_Z2,R_U,R_V},{OP_MUL,R_U,R_U,R_U},{OP_MUL,R_V,R_V,R_V},
      {OP_MUL,R_V,R_V,R_B},{OP_ADD,R_X2,R_U,R_V},{OP_STEP,R_X,R_X,R_X},
      {OP_MUL,R_T,R_Z1,R_Z2},{OP_MUL,R_WW,R_X,R_X},{OP_ADD,R_WW,R_WW,R_Y},
      {OP_MUL,R_WW,R_WW,R_T},{OP_MUL,R_T,R_X,R_T},{OP_MUL,R_U,R_T,R_ONE},
      {OP_MUL,R_U,R_U,R_U},{OP_MUL,R_U,R_U,R_T},{OP_LOOP,R_X,R_X,R_X},
      {OP_MUL,R_U,R_U,R_U},{OP_MUL,R_V,R_X,R_Z2},{OP_MUL,R_V,R_V,R_U},
      {OP_MUL,R_V,R_V,R_X1},{OP_MUL,R_T,R_X,R_Z1},{OP_ADD,R_T,R_T,R_X1},
      {OP_MUL,R_X1,R_X,R_Z2},{OP_ADD,R_X1,R_X1,R_X2},{OP_MUL,R_T,R_T,R_X1},
      {OP_ADD,R_T,R_T,R_WW},{OP_MUL,R_T,R_T,R_U},{OP_ADD,R_X1,R_X,R_V},
      {OP_MUL,R_T,R_T,R_X1},{OP_ADD,R_T,R_T,R_Y},UEND,
      {OP_MUL,R_U,R_X,R_X},{OP_MUL,R_V,R_U,R_X},{OP_MUL,R_WW,R_X,R_Y},
      {OP_ADD,R_V,R_V,R_WW},{OP_MUL,R_WW,R_Y,R_Y},{OP_ADD,R_V,R_V,R_WW},
      {OP_ADD,R_V,R_V,R_B},{OP_MUL,R_WW,R_U,R_A},{OP_ADD,R_V,R_V,R_WW}
   };

   // operand read, with the curve constants as fixed sources
   function automatic logic [M-1:0] rd(input logic [3:0] idx,
                                       input logic [M-1:0] v);
      unique case (idx)
         R_B:     rd = CURVE_B;
         R_ONE:   rd = {{(M-1){1'b0}}, 1'b1};
         R_A:     rd = CURVE_A;
         default: rd = v;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode
   logic [14:0]     instr;      // current micro-op
   uop_t            op;         // its opcode
   logic            swap;       // bit zero: ladder pairs exchange roles
   logic [3:0]      ed;         // effective destination
   logic [3:0]      ea;         // effective first source
   logic [3:0]      eb;         // effective second source
   logic [M-1:0]    op_a;       // first operand value
   logic [M-1:0]    op_b;       // second operand value
   logic [M-1:0]    mul_p;      // multiplier product
   logic            mul_done;   // product ready pulse
   logic            mul_start;  // launch a product
   logic            go;         // rising start
   logic            xfer;       // request acknowledged
   logic [PADW-1:0] in_cat;     // element with latest word
   logic [M-1:0]    in_val;     // element truncated to field
   logic            ld_k;       // scalar complete
   logic            ld_x;       // x complete
   logic            ld_y;       // y complete, ladder init
   logic            add_we;     // addition result write
   logic            is_pair;    // index names a ladder pair
   logic            pass;       // curve equation holds
   logic [PADW-1:0] stat_pad;   // status word, padded

   assign instr   = (pc_q <= 6'h2F) ? UCODE[pc_q] : UEND;
   assign op      = uop_t'(instr[14:12]);
   // ladder keeps one code path; a zero bit swaps the two point pairs
   assign swap    = (pc_q <= PC_LAST_LD) && !k_q[M-1];
   assign is_pair = (instr[11:8] >= R_X1) && (instr[11:8] <= R_Z2);
   assign ed = (swap && is_pair) ? (instr[11:8] ^ SWAP_XOR) : instr[11:8];
   assign ea = (swap && instr[7:4] >= R_X1 && instr[7:4] <= R_Z2)
               ? (instr[7:4] ^ SWAP_XOR) : instr[7:4];
   assign eb = (swap && instr[3:0] >= R_X1 && instr[3:0] <= R_Z2)
               ? (instr[3:0] ^ SWAP_XOR) : instr[3:0];
   assign op_a = rd(ea, (ea < 4'(RF_N)) ? rf_q[ea] : '0);
   assign op_b = rd(eb, (eb < 4'(RF_N)) ? rf_q[eb] : '0);

   assign go        = start && !start_q;
   assign mul_start = (state_q == S_EXEC) && (op == OP_MUL);
   assign add_we    = (state_q == S_EXEC) && (op == OP_ADD);
   assign xfer      = (rd_req_q || wr_req_q) && mem_ack;
   assign in_cat    = {mem_rd_data, in_buf_q[PADW-1:W]};
   assign in_val    = in_cat[M-1:0];
   assign ld_k = (state_q == S_LOAD) && xfer && (widx_q == WX_K_LAST);
   assign ld_x = (state_q == S_LOAD) && xfer && (widx_q == WX_X_LAST);
   assign ld_y = (state_q == S_LOAD) && xfer && (widx_q == WX_Y_LAST);
   assign pass = (rf_q[R_V] == '0);
   assign stat_pad = PADW'({mode_q, inf_q, mode_q & pass});

   assign done        = done_q;
   assign mem_rd_req  = rd_req_q;
   assign mem_wr_req  = wr_req_q;
   assign mem_addr    = addr_q;
   assign mem_wr_data = wdata_q;

   // one serial multiplier; the whole engine waits on it
   gf_mul u_mul (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .start   (mul_start),
      .a       (op_a),
      .b       (op_b),
      .p       (mul_p),
      .done    (mul_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // field registers: data path only, so no reset
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (ld_x) rf_q[R_X] <= in_val;
         if (ld_y) begin
            rf_q[R_Y]  <= in_val;
            // start from infinity and P; works for any leading bit
            rf_q[R_X1] <= {{(M-1){1'b0}}, 1'b1};
            rf_q[R_Z1] <= '0;
            rf_q[R_X2] <= rf_q[R_X];
            rf_q[R_Z2] <= {{(M-1){1'b0}}, 1'b1};
         end
         if (add_we) rf_q[ed] <= op_a ^ op_b;
         if (mul_done) rf_q[ed] <= mul_p;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequencer and memory requests
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q   <= S_IDLE;
         start_q   <= 1'b0;
         mode_q    <= 1'b0;
         done_q    <= 1'b0;
         rd_req_q  <= 1'b0;
         wr_req_q  <= 1'b0;
         addr_q    <= '0;
         wdata_q   <= '0;
         widx_q    <= '0;
         in_buf_q  <= '0;
         out_buf_q <= '0;
         k_q       <= '0;
         bits_q    <= 8'h00;
         loop_q    <= 8'h00;
         pc_q      <= 6'h00;
         inf_q     <= 1'b0;
      end else if (ce) begin
         start_q <= start;
         unique case (state_q)
            // idle and done accept a new start; done drops with it
            S_IDLE, S_DONE: begin
               if (go) begin
                  mode_q  <= mode;
                  done_q  <= 1'b0;
                  widx_q  <= WX_ZERO;
                  inf_q   <= 1'b0;
                  state_q <= S_LOAD;
               end
            end
            // fetch k, x, y word by word, least significant first
            S_LOAD: begin
               if (!rd_req_q) begin
                  rd_req_q <= 1'b1;
                  addr_q   <= K_BASE + AW'(widx_q);
               end else if (mem_ack) begin
                  rd_req_q <= 1'b0;
                  in_buf_q <= in_cat;
                  widx_q   <= widx_q + WXW'(1);
                  if (ld_k) k_q <= in_val;
                  if (ld_y) begin
                     bits_q  <= BIT_TOP;
                     pc_q    <= mode_q ? PC_VERIFY : PC_LADDER;
                     state_q <= S_EXEC;
                  end
               end
            end
            // run one micro-op; products go to the wait state
            S_EXEC: begin
               unique case (op)
                  OP_MUL: state_q <= S_MULW;
                  OP_ADD: pc_q <= pc_q + 6'h01;
                  OP_LOOP: begin
                     if (loop_q > 8'h01) begin
                        loop_q <= loop_q - 8'h01;
                        pc_q   <= pc_q - LOOP_BACK;
                     end else begin
                        pc_q <= pc_q + 6'h01;
                     end
                  end
                  OP_STEP: begin
                     if (bits_q != 8'h00) begin
                        bits_q <= bits_q - 8'h01;
                        k_q    <= {k_q[M-2:0], 1'b0};
                        pc_q   <= PC_LADDER;
                     end else begin
                        // kP at infinity has no affine form
                        inf_q  <= (rf_q[R_Z1] == '0);
                        loop_q <= INV_LOOPS;
                        pc_q   <= (rf_q[R_Z1] == '0) ? PC_END_MUL
                                                     : PC_POST;
                     end
                  end
                  OP_END: begin
                     widx_q    <= mode_q ? WX_STAT : WX_ZERO;
                     out_buf_q <= mode_q ? stat_pad
                                         : PADW'(rf_q[R_V]);
                     state_q   <= S_STORE;
                  end
               endcase
            end
            S_MULW: begin
               if (mul_done) begin
                  pc_q    <= pc_q + 6'h01;
                  state_q <= S_EXEC;
               end
            end
            // write x, y of Q, then the status word; verify writes the status word only
            S_STORE: begin
               if (!wr_req_q) begin
                  wr_req_q <= 1'b1;
                  addr_q   <= RES_BASE + AW'(widx_q);
                  wdata_q  <= out_buf_q[W-1:0];
               end else if (mem_ack) begin
                  wr_req_q <= 1'b0;
                  widx_q   <= widx_q + WXW'(1);
                  if (widx_q + WXW'(1) == WX_QY) begin
                     out_buf_q <= PADW'(rf_q[R_T]);
                  end else if (widx_q + WXW'(1) == WX_STAT) begin
                     out_buf_q <= stat_pad;
                  end else begin
                     out_buf_q <= out_buf_q >> W;
                  end
                  if (widx_q == WX_STAT) begin
                     done_q  <= 1'b1;
                     state_q <= S_DONE;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

endmodule // ec_point_engine

// >>> tb/ec_point_engine_checker.sv
// port assertions for the point multiply / verify engine
`timescale 1ns/10ps
module ec_point_engine_checker
   import ecpm_pkg::*;
(
   // clock, reset, enable
   input wire logic          sys_clk,
   input wire logic          rst,
   input wire logic          ce,
   // host control
   input wire logic          start,
   input wire logic          mode,
   input wire logic          done,
   // shared memory port
   input wire logic          mem_rd_req,
   input wire logic          mem_wr_req,
   input wire logic [AW-1:0] mem_addr,
   input wire logic [W-1:0]  mem_wr_data,
   input wire logic [W-1:0]  mem_rd_data,
   input wire logic          mem_ack
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // start edge taken while finished
   sequence s_go;
      ce && start && !$past(start) && done;
   endsequence
   // first operand fetch, one cycle after done falls
   sequence s_fetch;
      !done ##1 (mem_rd_req && mem_addr == K_BASE);
   endsequence

   ////////////////////////////////////////////////////////////////////
   chk_start_fetch: assert property (s_go |=> s_fetch)
      else $error("start edge did not lead to first fetch");
   chk_rd_hold: assert property (mem_rd_req && !mem_ack
      |=> mem_rd_req && $stable(mem_addr))
      else $error("read request moved before ack");
   chk_wr_hold: assert property (mem_wr_req && !mem_ack |=> mem_wr_req
      && $stable(mem_addr) && $stable(mem_wr_data))
      else $error("write request moved before ack");
   chk_req_drop: assert property ((mem_rd_req || mem_wr_req) && mem_ack
      |=> !mem_rd_req && !mem_wr_req)
      else $error("request not dropped after ack");
   chk_one_req: assert property (!(mem_rd_req && mem_wr_req))
      else $error("read and write requested together");
   chk_done_hold: assert property (done && !start |=> done)
      else $error("done fell without start");
   chk_done_quiet: assert property (done
      |-> !mem_rd_req && !mem_wr_req)
      else $error("memory traffic while done");
   chk_store_addr: assert property (mem_wr_req
      |-> mem_addr >= RES_BASE)
      else $error("write below result area");
   chk_load_addr: assert property (mem_rd_req
      |-> mem_addr < RES_BASE)
      else $error("read outside operand area");
   // one edge in: the very first edge may still sample power-up values
   chk_reset_clear: assert property (disable iff (1'b0) rst
      |=> !done && !mem_rd_req && !mem_wr_req)
      else $error("outputs not cleared in reset");
endmodule // ec_point_engine_checker

bind ec_point_engine ec_point_engine_checker ec_point_engine_checker_i (
   .sys_clk, .rst, .ce, .start, .mode, .done, .mem_rd_req, .mem_wr_req,
   .mem_addr, .mem_wr_data, .mem_rd_data, .mem_ack);

// >>> tb/shared_mem_model.sv
// arbitrated shared memory as seen by the engine
`timescale 1ns/10ps
module shared_mem_model
   import ecpm_pkg::*;
(
   // clock, reset, answer delay
   input wire logic          sys_clk,
   input wire logic          rst,
   input wire logic [3:0]    dly,
   // request side
   input wire logic          mem_rd_req,
   input wire logic          mem_wr_req,
   input wire logic [AW-1:0] mem_addr,
   input wire logic [W-1:0]  mem_wr_data,
   output logic [W-1:0]      mem_rd_data,
   output logic              mem_ack
);
   logic [W-1:0] words [0:31]; // host-visible storage
   logic [W-1:0] last_q;       // last bus value, for the idle pattern
   logic [3:0]   wait_q;       // stall cycles spent on this request
   int           n_rd = 0;     // reads answered
   int           n_wr = 0;     // writes answered

   // bus is undriven outside an answer: show a toggling pattern
   assign mem_rd_data = mem_ack ? words[mem_addr[4:0]] : ~last_q;

   ////////////////////////////////////////////////////////////////////
   // answer each request after dly stall cycles, one-cycle ack
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_ack <= 1'b0;
         wait_q  <= 4'h0;
         last_q  <= 32'h0;
      end else begin
         last_q <= mem_rd_data;
         if (mem_ack) begin
            mem_ack <= 1'b0;
            wait_q  <= 4'h0;
            if (mem_wr_req) begin
               words[mem_addr[4:0]] <= mem_wr_data;
               n_wr <= n_wr + 1;
            end
            if (mem_rd_req) begin
               n_rd <= n_rd + 1;
            end
         end else if ((mem_rd_req || mem_wr_req) && wait_q >= dly) begin
            mem_ack <= 1'b1;
         end else if (mem_rd_req || mem_wr_req) begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule // shared_mem_model

// >>> tb/ec_point_multiply_verify_bench.sv
// self-checking bench for the point multiply / verify engine
`timescale 1ns/10ps
module ec_point_multiply_verify_bench;
   import ecpm_pkg::*;
   logic          sys_clk, rst, ce, start, mode, done;
   logic          mem_rd_req, mem_wr_req, mem_ack;
   logic [AW-1:0] mem_addr;
   logic [W-1:0]  mem_wr_data, mem_rd_data;
   logic [3:0]    dly;            // memory stall cycles
   int            err_total  = 0; // mismatches
   int            num_checks = 0; // comparisons
   int            cyc        = 0; // watchdog count

   ec_point_engine ec_point_engine_i (.sys_clk, .rst, .ce, .start, .mode,
      .done, .mem_rd_req, .mem_wr_req, .mem_addr, .mem_wr_data,
      .mem_rd_data, .mem_ack);
   shared_mem_model shared_mem_model_i (.sys_clk, .rst, .dly, .mem_rd_req,
      .mem_wr_req, .mem_addr, .mem_wr_data, .mem_rd_data, .mem_ack);

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////
   // watchdog: runs well above three verifies and one abort
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         conclude();
      end
   end

   task automatic conclude();
      if (err_total == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one start pulse; done must be low one cycle after it is taken
   task automatic go(input logic m);
      @(negedge sys_clk);
      mode  = m;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      @(negedge sys_clk);
      check(32'(done), 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////
   // preload a point, verify it, judge the status word
   task automatic t_verify(input logic [M-1:0] px, input logic [M-1:0] py,
                           input logic pass, input logic [3:0] d);
      logic [PADW-1:0] ex, ey;
      int n;
      ex = PADW'(px);
      ey = PADW'(py);
      dly = d;
      for (n = 0; n < NW; n++) begin
         shared_mem_model_i.words[n]        = 32'h0000_0003;
         shared_mem_model_i.words[NW + n]   = ex[n*W +: W];
         shared_mem_model_i.words[2*NW + n] = ey[n*W +: W];
      end
      shared_mem_model_i.words[5*NW] = 32'hFFFF_FFFF; // status sentinel
      shared_mem_model_i.n_rd = 0;
      shared_mem_model_i.n_wr = 0;
      go(1'b1);
      for (n = 0; n < 40000 && done !== 1'b1; n++) begin
         @(negedge sys_clk);
      end
      check(32'(done), 32'h1);
      check(shared_mem_model_i.words[5*NW], {29'h0, 2'b10, pass});
      check(32'(shared_mem_model_i.n_rd), 32'(3*NW));
      check(32'(shared_mem_model_i.n_wr), 32'h1);
      repeat (5) @(negedge sys_clk);
      check(32'(done), 32'h1);
   endtask

   // multiply, then reset asynchronously while a read is stalled
   task automatic t_mul_abort();
      int n;
      dly = 4'hF;
      shared_mem_model_i.n_rd = 0;
      shared_mem_model_i.n_wr = 0;
      go(1'b0);
      for (n = 0; n < 2000 && shared_mem_model_i.n_rd < 3; n++) begin
         @(negedge sys_clk);
      end
      @(negedge sys_clk);
      check(32'(mem_rd_req), 32'h1);
      check(32'(mem_addr), 32'h3);
      #2 rst = 1'b1;
      #1 check({mem_rd_req, mem_wr_req, done}, 32'h0);
      check(32'(mem_addr), 32'h0);
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      check(32'(shared_mem_model_i.n_wr), 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst   = 1'b1;
      ce    = 1'b1;
      start = 1'b0;
      mode  = 1'b0;
      dly   = 4'h0;
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      t_verify(163'h0, 163'h1, 1'b1, 4'h0);
      t_verify(163'h0, 163'h0, 1'b0, 4'h3);
      t_mul_abort();
      t_verify(163'h0, 163'h1, 1'b1, 4'h2);
      conclude();
   end
endmodule // ec_point_multiply_verify_bench
